/* scr_pkg.sv */
// Summary of operation
// - Timeout n>0 holds rapid-lock 2*n reference cycles; zero disables.
// - Force with nonzero timeout holds rapid-lock; zero timeout invalid.
// - During rapid-lock pump follows rapid-lock gain; 0 is high impedance.
// - In steady state pump current follows steady gain; 0 is high impedance.
// - Output divider code v divides by 2*(v+1); codes 20 to 31 invalid.
// - Each output level runs 0 minimum to 47 maximum; 48 to 63 reserved.
// - Each output power-down bit at 1 powers that output down.
// - Doubler bit at 1 doubles the reference, at 0 passes it.
// - Polarity 0 positive, 1 negative (default); VCO use needs negative.
// - Calibration starts at core 0 to 3; avoid 3 below 2.2 GHz.
// - Order 0 integer, 1 to 3 delta-sigma order, 4 to 7 reserved.
// - Reference divider divides by code; 1 bypasses, 0 divides by 256.
// - Frequency write starts calibration unless calibration disable set.
// - Readback select 0 returns register contents, 1 the part code.
// - Dither codes 0 to 3 select weak, medium, strong, disabled.
// - Source 0 direct VCO, 1 divided VCO, 2 external input; 3 reserved.
package scr_pkg;

   localparam int          WORD_W      = 32;
   localparam int          ADDR_W      = 4;
   localparam int          NUM_REGS    = 5;
   localparam logic [3:0]  ADDR_FREQ   = 4'h0;
   localparam logic [3:0]  ADDR_PUMP   = 4'h1;
   localparam logic [3:0]  ADDR_DEN    = 4'h2;
   localparam logic [3:0]  ADDR_OUT    = 4'h3;
   localparam logic [3:0]  ADDR_LOCK   = 4'h4;

   // rapid_lock_bleed_ctrl
   localparam int FORCE_BIT    = 31;
   localparam int TOC_LSB      = 19;
   localparam int FLGAIN_LSB   = 14;
   localparam int BLEED_LSB    = 8;
   // output_divider_power_ctrl
   localparam int DIV_LSB      = 24;
   localparam int SLEVEL_LSB   = 18;
   localparam int FLEVEL_LSB   = 12;
   localparam int SPD_BIT      = 11;
   localparam int FPD_BIT      = 10;
   localparam int SSRC_LSB     = 8;
   localparam int FSRC_LSB     = 6;
   // doubler_polarity_denominator
   localparam int DBL_BIT      = 27;
   localparam int POL_BIT      = 26;
   localparam int DEN_LSB      = 4;
   // pump_core_order_refdiv
   localparam int SGAIN_LSB    = 27;
   localparam int CORE_LSB     = 25;
   localparam int ORDER_LSB    = 22;
   localparam int REFDIV_LSB   = 4;
   // frequency_control
   localparam int RBSEL_BIT    = 31;
   localparam int DITHER_LSB   = 29;
   localparam int CALDIS_BIT   = 28;
   localparam int FBDIV_LSB    = 16;

   localparam logic [31:0] FREQ_RESET  = 32'h0000_0000;
   localparam logic [31:0] PUMP_RESET  = 32'h0000_0000;
   localparam logic [31:0] DEN_RESET   = 32'h0400_0000;
   localparam logic [31:0] OUT_RESET   = 32'h0000_0000;
   localparam logic [31:0] LOCK_RESET  = 32'h0000_0000;

   localparam logic [4:0]  DIV_INVALID_MIN = 5'h14;
   localparam logic [5:0]  LEVEL_MAX       = 6'h2f;
   localparam logic [8:0]  REFDIV_FULL     = 9'h100;
   localparam logic [2:0]  ORDER_MAX       = 3'h3;
   localparam logic [1:0]  SOURCE_RESERVED = 2'h3;
   localparam int          COUNT_W         = 13;

   typedef struct packed {
      logic        rapid_lock_force;
      logic [11:0] rapid_lock_timeout_count;
      logic [4:0]  rapid_lock_pump_gain;
      logic [5:0]  pump_bleed_setting;
      logic [4:0]  output_divider_code;
      logic [5:0]  second_output_level;
      logic [5:0]  first_output_level;
      logic        second_output_power_down;
      logic        first_output_power_down;
      logic [1:0]  second_output_source;
      logic [1:0]  first_output_source;
      logic        reference_doubler_enable;
      logic        charge_pump_polarity;
      logic [21:0] fraction_denominator;
      logic [4:0]  steady_pump_gain;
      logic [1:0]  core_start_select;
      logic [2:0]  modulator_order;
      logic [7:0]  reference_divider;
      logic        part_code_readback_select;
      logic [1:0]  dither_mode;
      logic        calibration_disable;
      logic [11:0] feedback_divider;
   } scr_cfg_type;

endpackage : scr_pkg

/* scr_config_registers.sv */
`timescale 1ns/1ps
module scr_config_registers
   import scr_pkg::*;
#(
   parameter logic [31:0] PART_CODE = 32'h0000_00a5 // Arbitrary value
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        serial_clock,
   input  wire logic        serial_data,
   input  wire logic        latch_enable,
   input  wire logic        reference_input,
   output logic             readback_data,
   output scr_cfg_type      cfg,
   output logic             rapid_lock_engaged,
   output logic             force_timeout_invalid,
   output logic [4:0]       pump_gain_active,
   output logic             pump_high_impedance,
   output logic [5:0]       output_divider_ratio,
   output logic             output_divider_invalid,
   output logic             first_output_enable,
   output logic             second_output_enable,
   output logic             output_level_reserved,
   output logic             output_source_reserved,
   output logic             modulator_reserved,
   output logic [8:0]       reference_divider_ratio,
   output logic             calibration_start
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0]        sync_a;
   logic [3:0]        sync_b;
   logic [3:0]        sync_d;
   logic [WORD_W-1:0] shift_in;
   logic [WORD_W-1:0] shift_out;
   logic [WORD_W-1:0] regs [0:NUM_REGS-1];
   logic [COUNT_W-1:0] lock_count;

   function automatic logic rising(input logic now_level,
                                   input logic old_level);
      return now_level & ~old_level;
   endfunction : rising

   // Order: serial clock, data, latch, reference
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
         sync_d <= 4'h0;
      end
      else
      begin
         sync_a <= {reference_input, latch_enable, serial_data,
                    serial_clock};
         sync_b <= sync_a;
         sync_d <= sync_b;
      end
   end

   wire sclk_rise  = rising(sync_b[0], sync_d[0]);
   wire data_bit   = sync_b[1];
   wire le_level   = sync_b[2];
   wire le_rise    = rising(sync_b[2], sync_d[2]);
   // Doubled reference counts both edges of the input
   wire ref_rise   = rising(sync_b[3], sync_d[3]);
   wire ref_edge   = sync_b[3] ^ sync_d[3];

   // ----------------------------------------------------------------
   // Serial shift and commit
   // ----------------------------------------------------------------
   // Bits shift only while the latch is low; the low nibble is the address
   wire [ADDR_W-1:0] wr_addr  = shift_in[ADDR_W-1:0];
   wire              wr_hit   = le_rise && (wr_addr < ADDR_W'(NUM_REGS));
   wire              freq_wr  = le_rise && (wr_addr == ADDR_FREQ);
   wire [WORD_W-1:0] wr_word  = {shift_in[WORD_W-1:ADDR_W], {ADDR_W{1'b0}}};

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         shift_in <= '0;
      else if (sclk_rise && !le_level)
         shift_in <= {shift_in[WORD_W-2:0], data_bit};
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         regs[0] <= FREQ_RESET;
         regs[1] <= PUMP_RESET;
         regs[2] <= DEN_RESET;
         regs[3] <= OUT_RESET;
         regs[4] <= LOCK_RESET;
      end
      else if (wr_hit)
         regs[wr_addr[2:0]] <= wr_word;
   end

   // ----------------------------------------------------------------
   // Field unpacking
   // ----------------------------------------------------------------
   wire [31:0] r0 = regs[ADDR_FREQ[2:0]];
   wire [31:0] r1 = regs[ADDR_PUMP[2:0]];
   wire [31:0] r2 = regs[ADDR_DEN[2:0]];
   wire [31:0] r3 = regs[ADDR_OUT[2:0]];
   wire [31:0] r4 = regs[ADDR_LOCK[2:0]];

   assign cfg.rapid_lock_force          = r4[FORCE_BIT];
   assign cfg.rapid_lock_timeout_count  = r4[TOC_LSB +: 12];
   assign cfg.rapid_lock_pump_gain      = r4[FLGAIN_LSB +: 5];
   assign cfg.pump_bleed_setting        = r4[BLEED_LSB +: 6];
   assign cfg.output_divider_code       = r3[DIV_LSB +: 5];
   assign cfg.second_output_level       = r3[SLEVEL_LSB +: 6];
   assign cfg.first_output_level        = r3[FLEVEL_LSB +: 6];
   assign cfg.second_output_power_down  = r3[SPD_BIT];
   assign cfg.first_output_power_down   = r3[FPD_BIT];
   assign cfg.second_output_source      = r3[SSRC_LSB +: 2];
   assign cfg.first_output_source       = r3[FSRC_LSB +: 2];
   assign cfg.reference_doubler_enable  = r2[DBL_BIT];
   assign cfg.charge_pump_polarity      = r2[POL_BIT];
   assign cfg.fraction_denominator      = r2[DEN_LSB +: 22];
   assign cfg.steady_pump_gain          = r1[SGAIN_LSB +: 5];
   assign cfg.core_start_select         = r1[CORE_LSB +: 2];
   assign cfg.modulator_order           = r1[ORDER_LSB +: 3];
   assign cfg.reference_divider         = r1[REFDIV_LSB +: 8];
   assign cfg.part_code_readback_select = r0[RBSEL_BIT];
   assign cfg.dither_mode               = r0[DITHER_LSB +: 2];
   assign cfg.calibration_disable       = r0[CALDIS_BIT];
   assign cfg.feedback_divider          = r0[FBDIV_LSB +: 12];

   // ----------------------------------------------------------------
   // Decoded controls
   // ----------------------------------------------------------------
   wire toc_zero = (cfg.rapid_lock_timeout_count == 12'h000);

   assign force_timeout_invalid = cfg.rapid_lock_force && toc_zero;
   assign rapid_lock_engaged =
      (cfg.rapid_lock_force && !toc_zero) || (lock_count != '0);
   assign pump_gain_active = rapid_lock_engaged ?
      cfg.rapid_lock_pump_gain : cfg.steady_pump_gain;
   assign pump_high_impedance = (pump_gain_active == 5'h00);

   assign output_divider_ratio =
      {cfg.output_divider_code, 1'b0} + 6'h02;
   assign output_divider_invalid =
      (cfg.output_divider_code >= DIV_INVALID_MIN);
   assign output_level_reserved =
      (cfg.first_output_level > LEVEL_MAX) ||
      (cfg.second_output_level > LEVEL_MAX);
   assign first_output_enable  = !cfg.first_output_power_down;
   assign second_output_enable = !cfg.second_output_power_down;
   assign output_source_reserved =
      (cfg.first_output_source == SOURCE_RESERVED) ||
      (cfg.second_output_source == SOURCE_RESERVED);
   assign modulator_reserved = (cfg.modulator_order > ORDER_MAX);
   assign reference_divider_ratio = (cfg.reference_divider == 8'h00) ?
      REFDIV_FULL : {1'b0, cfg.reference_divider};

   // ----------------------------------------------------------------
   // Rapid-lock timeout counter
   // ----------------------------------------------------------------
   // Reload uses the timeout already held, so program it before the
   // frequency word. Reference must run below a quarter of ref_clk.
   wire ref_tick = cfg.reference_doubler_enable ? ref_edge : ref_rise;
   wire [COUNT_W-1:0] next_lock_count =
      freq_wr ? {cfg.rapid_lock_timeout_count, 1'b0} :
      (ref_tick && lock_count != '0) ? lock_count - 1'b1 : lock_count;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         lock_count <= '0;
      else
         lock_count <= next_lock_count;
   end

   // ----------------------------------------------------------------
   // Calibration trigger and readback
   // ----------------------------------------------------------------
   // New word decides: the flag comes from the word being written
   wire next_cal = freq_wr && !shift_in[CALDIS_BIT];
   wire [WORD_W-1:0] rb_word = cfg.part_code_readback_select ? PART_CODE :
      (wr_addr < ADDR_W'(NUM_REGS)) ? regs[wr_addr[2:0]] : '0;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         calibration_start <= 1'b0;
         shift_out         <= '0;
         readback_data     <= 1'b0;
      end
      else
      begin
         calibration_start <= next_cal;
         readback_data     <= shift_out[WORD_W-1];
         if (le_rise)
            shift_out <= rb_word;
         else if (sclk_rise && !le_level)
            shift_out <= {shift_out[WORD_W-2:0], 1'b0};
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_cal_on_write: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      freq_wr |=> (calibration_start == !$past(shift_in[CALDIS_BIT])))
      else $error("calibration start does not follow frequency write");

   a_cal_needs_write: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      calibration_start |-> $past(freq_wr) && !cfg.calibration_disable)
      else $error("calibration start without frequency write");

   a_count_reload: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      freq_wr |=> lock_count == {$past(cfg.rapid_lock_timeout_count), 1'b0})
      else $error("timeout counter did not reload to twice the count");

   a_count_steps: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !freq_wr && lock_count != '0 && !ref_tick |=> $stable(lock_count))
      else $error("timeout counter moved without a reference edge");

   a_lock_disabled: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      toc_zero && $past(toc_zero) && !$past(freq_wr) && lock_count == '0
      |-> !rapid_lock_engaged)
      else $error("rapid-lock engaged with zero timeout");

   a_lock_forced: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      cfg.rapid_lock_force && !toc_zero |-> rapid_lock_engaged)
      else $error("forced rapid-lock not engaged");

   a_gain_select: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rapid_lock_engaged |-> pump_gain_active == cfg.rapid_lock_pump_gain)
      else $error("rapid-lock gain not applied");

   a_gain_steady: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !rapid_lock_engaged |-> pump_gain_active == cfg.steady_pump_gain
         && pump_high_impedance == (cfg.steady_pump_gain == 5'h00))
      else $error("steady gain not applied");

   a_divider_ratio: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      output_divider_ratio == 6'(2 * (cfg.output_divider_code + 1)))
      else $error("output divider ratio wrong");

   a_refdiv_full: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      cfg.reference_divider == 8'h00 |-> reference_divider_ratio == 9'd256)
      else $error("reference divider code zero not 256");

   a_readback_code: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      le_rise && cfg.part_code_readback_select |=> shift_out == PART_CODE)
      else $error("part code not loaded for readback");

   a_power_down: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      first_output_enable == !cfg.first_output_power_down)
      else $error("first output not powered down");

   a_second_down: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      second_output_enable == !cfg.second_output_power_down)
      else $error("second output not powered down");

   a_level_reserved: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      output_level_reserved == (cfg.first_output_level >= 6'h30 ||
                                cfg.second_output_level >= 6'h30))
      else $error("reserved output level not flagged");

   a_divider_invalid: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      output_divider_invalid == (cfg.output_divider_code > 5'h13))
      else $error("invalid divider code not flagged");

   a_source_reserved: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      output_source_reserved ==
         (&cfg.first_output_source || &cfg.second_output_source))
      else $error("reserved output source not flagged");

   a_order_reserved: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      modulator_reserved == cfg.modulator_order[2])
      else $error("reserved modulator order not flagged");

   a_force_invalid: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      force_timeout_invalid ==
         (cfg.rapid_lock_force && cfg.rapid_lock_timeout_count == 12'h000))
      else $error("force with zero timeout not flagged");

   a_count_decrement: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !freq_wr && ref_tick && lock_count != '0
      |=> lock_count == $past(lock_count) - 1'b1)
      else $error("timeout counter did not step down on a reference edge");

endmodule : scr_config_registers

/* scr_host_model.sv */
`timescale 1ns/1ps
module scr_host_model
   import scr_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic readback_data,
   input  wire logic calibration_start,
   output logic      serial_clock,
   output logic      serial_data,
   output logic      latch_enable
);
   // Four cycles a phase: two for the pin synchroniser plus margin
   localparam int PHASE = 4;

   initial
   begin
      serial_clock = 1'b0;
      serial_data  = 1'b0;
      latch_enable = 1'b0;
   end

   // ------------------------------------------------------------
   // One 32-bit frame, MSB first, readback captured on the way
   // ------------------------------------------------------------
   task automatic xfer(input  logic [31:0] word,
                       output logic [31:0] rb,
                       output int          cal);
      cal = 0;
      for (int i = 31; i >= 0; i--)
      begin
         @(posedge ref_clk);
         serial_data <= word[i];
         repeat (PHASE) @(posedge ref_clk);
         rb[i] = readback_data;
         serial_clock <= 1'b1;
         repeat (PHASE) @(posedge ref_clk);
         serial_clock <= 1'b0;
      end
      @(posedge ref_clk);
      latch_enable <= 1'b1;
      // Data line no longer meaningful, so it shows the inverse
      serial_data  <= ~word[0];
      repeat (8)
      begin
         @(posedge ref_clk);
         #1 if (calibration_start === 1'b1) cal++;
      end
      @(posedge ref_clk);
      latch_enable <= 1'b0;
   endtask : xfer
endmodule : scr_host_model

/* scr_config_registers_test.sv */
`timescale 1ns/1ps
module scr_config_registers_test
   import scr_pkg::*;
;
   localparam logic [31:0] HOST_PART_CODE = 32'h0000_005c; // Arbitrary value
   logic        ref_clk, rst_n, reference_input, readback_data;
   logic        serial_clock, serial_data, latch_enable;
   scr_cfg_type cfg;
   logic        rapid_lock_engaged, force_timeout_invalid;
   logic [4:0]  pump_gain_active;
   logic        pump_high_impedance, output_divider_invalid;
   logic [5:0]  output_divider_ratio;
   logic        first_output_enable, second_output_enable;
   logic        output_level_reserved, output_source_reserved;
   logic        modulator_reserved, calibration_start;
   logic [8:0]  reference_divider_ratio;
   logic [31:0] rb;
   int          cal, miscompares, samples_checked;
   logic [7:0]  refdivs [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                                8'h10, 8'h80, 8'hfe, 8'hff};
   logic [4:0]  divs [4] = '{5'h00, 5'h12, 5'h13, 5'h14};
   logic [5:0]  lv [4] = '{6'h00, 6'h2f, 6'h30, 6'h3f};

   scr_config_registers #(.PART_CODE(HOST_PART_CODE)) scr_config_registers_i
   (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clock(serial_clock),
    .serial_data(serial_data), .latch_enable(latch_enable),
    .reference_input(reference_input), .readback_data(readback_data),
    .cfg(cfg), .rapid_lock_engaged(rapid_lock_engaged),
    .force_timeout_invalid(force_timeout_invalid),
    .pump_gain_active(pump_gain_active),
    .pump_high_impedance(pump_high_impedance),
    .output_divider_ratio(output_divider_ratio),
    .output_divider_invalid(output_divider_invalid),
    .first_output_enable(first_output_enable),
    .second_output_enable(second_output_enable),
    .output_level_reserved(output_level_reserved),
    .output_source_reserved(output_source_reserved),
    .modulator_reserved(modulator_reserved),
    .reference_divider_ratio(reference_divider_ratio),
    .calibration_start(calibration_start));

   scr_host_model scr_host_model_i
   (.ref_clk(ref_clk), .readback_data(readback_data),
    .calibration_start(calibration_start), .serial_clock(serial_clock),
    .serial_data(serial_data), .latch_enable(latch_enable));

   always #50 ref_clk = ~ref_clk;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [31:0] word);
      scr_host_model_i.xfer(word, rb, cal);
   endtask : wr

   task automatic ref_pulses(input int n);
      repeat (n)
      begin
         @(posedge ref_clk) reference_input <= 1'b1;
         repeat (5) @(posedge ref_clk);
         reference_input <= 1'b0;
         repeat (5) @(posedge ref_clk);
      end
   endtask : ref_pulses

   // Feedback 14 suits any order; dis sets the calibration disable bit
   function automatic logic [31:0] fw(input logic dis, input logic sel);
      return (32'(sel) << RBSEL_BIT) | (32'h3 << DITHER_LSB)
             | (32'(dis) << CALDIS_BIT) | (32'd14 << FBDIV_LSB)
             | 32'(ADDR_FREQ);
   endfunction : fw

   function automatic logic [31:0] lw(input logic f, input logic [11:0] t);
      return (32'(f) << FORCE_BIT) | (32'(t) << TOC_LSB)
             | (32'd9 << FLGAIN_LSB) | (32'd4 << BLEED_LSB) | 32'(ADDR_LOCK);
   endfunction : lw

   function automatic logic [31:0] dw(input logic dbl);
      return (32'(dbl) << DBL_BIT) | (32'h1 << POL_BIT)
             | (32'h2a_5a5a << DEN_LSB) | 32'(ADDR_DEN);
   endfunction : dw

   initial
   begin
      #4_000_000;
      miscompares++;
      report_and_stop();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      reference_input = 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check(cfg.charge_pump_polarity, 1);
      check(output_divider_ratio, 2);
      check(reference_divider_ratio, 256);
      check(pump_high_impedance, 1);
      wr(dw(1'b0));
      check(cfg.fraction_denominator, 22'h2a_5a5a);
      check(cfg.reference_doubler_enable, 0);
      for (int i = 0; i < 8; i++)
      begin
         wr((32'(i * 4) << SGAIN_LSB) | (32'(i % 4) << CORE_LSB)
            | (32'(i) << ORDER_LSB) | (32'(refdivs[i]) << REFDIV_LSB)
            | 32'(ADDR_PUMP));
         if (i == 0) check(rb[31:4], DEN_RESET[31:4]);
         check(modulator_reserved, i > 3);
         check(cfg.modulator_order, i);
         check(reference_divider_ratio, {refdivs[i] == 0, refdivs[i]});
         check(pump_gain_active, i * 4);
         check(pump_high_impedance, i == 0);
         check(cfg.core_start_select, i % 4);
      end
      wr((32'd12 << SGAIN_LSB) | (32'd2 << ORDER_LSB) | (32'd1 << REFDIV_LSB)
         | 32'(ADDR_PUMP));
      for (int i = 0; i < 4; i++)
      begin
         wr((32'(divs[i]) << DIV_LSB) | (32'(lv[i ^ 1]) << SLEVEL_LSB)
            | (32'(lv[i]) << FLEVEL_LSB) | (32'(i[1]) << SPD_BIT)
            | (32'(i[0]) << FPD_BIT) | (32'(3 - i) << SSRC_LSB)
            | (32'(i) << FSRC_LSB) | 32'(ADDR_OUT));
         check(output_divider_invalid, divs[i] >= 20);
         if (divs[i] < 20) check(output_divider_ratio, 2 * divs[i] + 2);
         check(output_level_reserved, i > 1);
         check(cfg.first_output_level, lv[i]);
         check(first_output_enable, !i[0]);
         check(second_output_enable, !i[1]);
         check(output_source_reserved, i == 0 || i == 3);
         check(cfg.first_output_source, i);
      end
      wr(lw(1'b0, 12'h003));
      check(rapid_lock_engaged, 0);
      check(cfg.pump_bleed_setting, 4);
      wr(fw(1'b0, 1'b0));
      check(cal, 1);
      check(cfg.dither_mode, 3);
      check(cfg.feedback_divider, 14);
      check(rapid_lock_engaged, 1);
      check(pump_gain_active, 9);
      ref_pulses(5);
      check(rapid_lock_engaged, 1);
      ref_pulses(1);
      check(rapid_lock_engaged, 0);
      check(pump_gain_active, 12);
      wr(fw(1'b1, 1'b0));
      check(cal, 0);
      check(rapid_lock_engaged, 1);
      wr(lw(1'b1, 12'h003));
      wr(fw(1'b1, 1'b0));
      ref_pulses(7);
      check(rapid_lock_engaged, 1);
      check(force_timeout_invalid, 0);
      wr(lw(1'b1, 12'h000));
      check(force_timeout_invalid, 1);
      check(rapid_lock_engaged, 0);
      wr(dw(1'b1));
      check(cfg.reference_doubler_enable, 1);
      wr(lw(1'b0, 12'h003));
      wr(fw(1'b1, 1'b0));
      ref_pulses(2);
      check(rapid_lock_engaged, 1);
      ref_pulses(1);
      check(rapid_lock_engaged, 0);
      wr(fw(1'b1, 1'b1));
      wr(fw(1'b1, 1'b0));
      wr(32'hffff_fff5);
      check(rb, HOST_PART_CODE);
      check(cfg.output_divider_code, 5'h14);
      check(cfg.rapid_lock_timeout_count, 12'h003);
      wr(32'h0000_0006);
      check(rb[31:4], 28'h0);
      report_and_stop();
   end
endmodule : scr_config_registers_test
